// *** design/counter_array_params.svh ***
// Constants for the counter array modulation and watchdog block
`ifndef COUNTER_ARRAY_PARAMS_SVH
`define COUNTER_ARRAY_PARAMS_SVH
// Register indices
`define CA_ADDR_ARRAY_MODE 8'h00
`define CA_ADDR_RUN 8'h01
`define CA_ADDR_TIMER_LOW 8'h02
`define CA_ADDR_TIMER_HIGH 8'h03
`define CA_ADDR_PINS 8'h04
`define CA_ADDR_STATUS 8'h05
`define CA_ADDR_MODE_BASE 8'h10
`define CA_ADDR_LOW_BASE 8'h20
`define CA_ADDR_HIGH_BASE 8'h30
// Mode register fields
`define CA_BIT_COMPARATOR_ENABLE 6
`define CA_BIT_MATCH_FLAG_ENABLE 3
`define CA_BIT_TOGGLE_ON_MATCH 2
`define CA_BIT_MODULATION_ENABLE 1
// Array mode register: watchdog enable is value 40H
`define CA_BIT_WATCHDOG_ENABLE 6
`define CA_BIT_COUNT_SOURCE 0
// Reset value and watchdog module index
`define CA_RST_BYTE 8'h00
`define CA_WD_MODULE 4
`endif

// *** design/counter_array_pkg.sv ***
// Types for the counter array block
package counter_array_pkg;
  typedef enum logic [3:0] {
    MODE_IDLE = 4'b0001,
    MODE_TIMER = 4'b0010,
    MODE_TOGGLE = 4'b0100,
    MODE_PWM = 4'b1000
  } module_mode_t;
endpackage : counter_array_pkg

// *** design/compare_module.sv ***
// One compare module: modulation, compare timer and toggle modes
`timescale 1ns/1ps
`include "counter_array_params.svh"
module compare_module (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic step_i,
  input wire logic [15:0] timer_i,
  input wire logic [7:0] mode_i,
  input wire logic [7:0] reload_i,
  input wire logic wr_active_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] active_o,
  output logic match_o,
  output logic pin_o
);
  counter_array_pkg::module_mode_t mode;
  logic [7:0] active_r;
  logic [7:0] active_nxt;
  logic pin_r;
  logic pin_nxt;
  logic match_r;
  logic match_nxt;
  logic hit;

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  always_comb
  begin
    mode = counter_array_pkg::MODE_IDLE;
    if (mode_i[`CA_BIT_COMPARATOR_ENABLE] && mode_i[`CA_BIT_MODULATION_ENABLE])
      mode = counter_array_pkg::MODE_PWM;
    else if (mode_i[`CA_BIT_COMPARATOR_ENABLE] && mode_i[`CA_BIT_MATCH_FLAG_ENABLE]
             && mode_i[`CA_BIT_TOGGLE_ON_MATCH])
      mode = counter_array_pkg::MODE_TOGGLE;
    else if (mode_i[`CA_BIT_COMPARATOR_ENABLE] && mode_i[`CA_BIT_MATCH_FLAG_ENABLE])
      mode = counter_array_pkg::MODE_TIMER;
  end

  // Compare byte low half in the active byte, high half in the reload byte
  assign hit = step_i && (timer_i == {reload_i, active_r});

  // Next state of compare byte, pin and match pulse
  always_comb
  begin
    active_nxt = active_r;
    pin_nxt = pin_r;
    match_nxt = 1'b0;
    if (wr_active_i)
      active_nxt = wdata_i;
    unique case (mode)
      counter_array_pkg::MODE_PWM:
      begin
        if (step_i && timer_i[7:0] == 8'hFF)
          active_nxt = reload_i;
        pin_nxt = (timer_i[7:0] >= active_r);
      end
      counter_array_pkg::MODE_TOGGLE:
      begin
        match_nxt = hit;
        if (hit)
          pin_nxt = ~pin_r;
      end
      counter_array_pkg::MODE_TIMER:
        match_nxt = hit;
      counter_array_pkg::MODE_IDLE:
        match_nxt = 1'b0;
    endcase
  end

  // Registers
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      active_r <= `CA_RST_BYTE;
      pin_r <= 1'b1;
      match_r <= 1'b0;
    end
    else if (ce_i)
    begin
      active_r <= active_nxt;
      pin_r <= pin_nxt;
      match_r <= match_nxt;
    end
  end

  assign active_o = active_r;
  assign match_o = match_r;
  assign pin_o = pin_r;
endmodule : compare_module

// *** design/counter_array_pwm_watchdog.sv ***
// Counter array top: shared timer, register port, compare modules, watchdog
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "counter_array_params.svh"
module counter_array_pwm_watchdog #(
  parameter int NUM_MODULES = 5
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic count_src_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic [NUM_MODULES-1:0] module_pin_o,
  output logic wd_reset_o,
  output logic [15:0] timer_o
);
  logic [7:0] array_mode_reg_r;
  logic [7:0] array_mode_reg_nxt;
  logic run_r;
  logic run_nxt;
  logic [15:0] timer_r;
  logic [15:0] timer_nxt;
  logic [7:0] mode_r [NUM_MODULES];
  logic [7:0] mode_nxt [NUM_MODULES];
  logic [7:0] reload_r [NUM_MODULES];
  logic [7:0] reload_nxt [NUM_MODULES];
  logic [7:0] active [NUM_MODULES];
  logic [NUM_MODULES-1:0] pins;
  logic [NUM_MODULES-1:0] match;
  logic [NUM_MODULES-1:0] match_seen_r;
  logic [NUM_MODULES-1:0] match_seen_nxt;
  logic [2:0] src_sync_r;
  logic [2:0] src_sync_nxt;
  logic src_level_r;
  logic src_level_nxt;
  logic step;
  logic wd_armed;
  logic wd_reset_r;
  logic wd_reset_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [NUM_MODULES-1:0] pin_out_r;

  // ----------------------------------------
  // Count source sync and step detect
  // ----------------------------------------
  // Three stages; level changes once the last two agree
  always_comb
  begin
    src_sync_nxt = {src_sync_r[1:0], count_src_i};
    src_level_nxt = src_level_r;
    if (src_sync_r[2] == src_sync_r[1])
      src_level_nxt = src_sync_r[2];
  end

  // Timer advances on rising edge of the selected source, or every clock
  assign step = run_r && (array_mode_reg_r[`CA_BIT_COUNT_SOURCE] ?
                          (src_level_nxt && !src_level_r) : 1'b1);

  // ----------------------------------------
  // Control registers and timer
  // ----------------------------------------
  always_comb
  begin
    array_mode_reg_nxt = array_mode_reg_r;
    run_nxt = run_r;
    timer_nxt = timer_r;
    if (step)
      timer_nxt = timer_r + 16'h0001;
    for (int i = 0; i < NUM_MODULES; i++)
    begin
      mode_nxt[i] = mode_r[i];
      reload_nxt[i] = reload_r[i];
      if (wr_i && addr_i == `CA_ADDR_MODE_BASE + 8'(i))
        mode_nxt[i] = wdata_i;
      if (wr_i && addr_i == `CA_ADDR_HIGH_BASE + 8'(i))
        reload_nxt[i] = wdata_i;
    end
    if (wr_i)
    begin
      unique case (addr_i)
        `CA_ADDR_ARRAY_MODE: array_mode_reg_nxt = wdata_i;
        `CA_ADDR_RUN: run_nxt = wdata_i[0];
        `CA_ADDR_TIMER_LOW: timer_nxt[7:0] = wdata_i;
        `CA_ADDR_TIMER_HIGH: timer_nxt[15:8] = wdata_i;
        default: ;
      endcase
    end
  end

  // Sticky match status: set wins over a clearing write
  always_comb
  begin
    match_seen_nxt = match_seen_r;
    if (wr_i && addr_i == `CA_ADDR_STATUS)
      match_seen_nxt = match_seen_r & ~wdata_i[NUM_MODULES-1:0];
    match_seen_nxt = match_seen_nxt | match;
  end

  // ----------------------------------------
  // Compare modules
  // ----------------------------------------
  for (genvar g = 0; g < NUM_MODULES; g++)
  begin : g_mod
    compare_module u_mod (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .step_i(step),
      .timer_i(timer_r),
      .mode_i(mode_r[g]),
      .reload_i(reload_r[g]),
      .wr_active_i(wr_i && addr_i == `CA_ADDR_LOW_BASE + 8'(g)),
      .wdata_i(wdata_i),
      .active_o(active[g]),
      .match_o(match[g]),
      .pin_o(pins[g])
    );
  end

  // ----------------------------------------
  // Watchdog on module four
  // ----------------------------------------
  // Armed with enable bit set and module four in either compare mode
  assign wd_armed = array_mode_reg_r[`CA_BIT_WATCHDOG_ENABLE]
                    && mode_r[`CA_WD_MODULE][`CA_BIT_COMPARATOR_ENABLE]
                    && mode_r[`CA_WD_MODULE][`CA_BIT_MATCH_FLAG_ENABLE]
                    && !mode_r[`CA_WD_MODULE][`CA_BIT_MODULATION_ENABLE];

  // Full 16-bit equality sampled on each timer step
  assign wd_reset_nxt = wd_armed && step
                        && timer_r == {reload_r[`CA_WD_MODULE], active[`CA_WD_MODULE]};

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  always_comb
  begin
    rdata_nxt = 8'h00;
    for (int i = 0; i < NUM_MODULES; i++)
    begin
      if (addr_i == `CA_ADDR_MODE_BASE + 8'(i))
        rdata_nxt = mode_r[i];
      if (addr_i == `CA_ADDR_LOW_BASE + 8'(i))
        rdata_nxt = active[i];
      if (addr_i == `CA_ADDR_HIGH_BASE + 8'(i))
        rdata_nxt = reload_r[i];
    end
    unique case (addr_i)
      `CA_ADDR_ARRAY_MODE: rdata_nxt = array_mode_reg_r;
      `CA_ADDR_RUN: rdata_nxt = {7'h00, run_r};
      `CA_ADDR_TIMER_LOW: rdata_nxt = timer_r[7:0];
      `CA_ADDR_TIMER_HIGH: rdata_nxt = timer_r[15:8];
      `CA_ADDR_PINS: rdata_nxt = 8'(pins);
      `CA_ADDR_STATUS: rdata_nxt = 8'(match_seen_r);
      default: ;
    endcase
    if (!rd_i)
      rdata_nxt = 8'h00;
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      array_mode_reg_r <= `CA_RST_BYTE;
      run_r <= 1'b0;
      timer_r <= 16'h0000;
      for (int i = 0; i < NUM_MODULES; i++)
      begin
        mode_r[i] <= `CA_RST_BYTE;
        reload_r[i] <= `CA_RST_BYTE;
      end
      match_seen_r <= '0;
      src_sync_r <= 3'h0;
      src_level_r <= 1'b0;
      wd_reset_r <= 1'b0;
      rdata_r <= 8'h00;
      pin_out_r <= '1;
    end
    else if (ce_i)
    begin
      array_mode_reg_r <= array_mode_reg_nxt;
      run_r <= run_nxt;
      timer_r <= timer_nxt;
      for (int i = 0; i < NUM_MODULES; i++)
      begin
        mode_r[i] <= mode_nxt[i];
        reload_r[i] <= reload_nxt[i];
      end
      match_seen_r <= match_seen_nxt;
      src_sync_r <= src_sync_nxt;
      src_level_r <= src_level_nxt;
      wd_reset_r <= wd_reset_nxt;
      rdata_r <= rdata_nxt;
      pin_out_r <= pins;
    end
  end

  assign rdata_o = rdata_r;
  assign module_pin_o = pin_out_r;
  assign wd_reset_o = wd_reset_r;
  assign timer_o = timer_r;
endmodule : counter_array_pwm_watchdog

// *** tb/counter_array_assertions.sv ***
// Checker for the counter array block ports
`timescale 1ns/1ps
module counter_array_checker #(
  parameter int NUM_MODULES = 5
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [NUM_MODULES-1:0] module_pin_o,
  input wire logic wd_reset_o,
  input wire logic [15:0] timer_o
);
  logic [15:0] cmp_r;
  logic wden_r;
  // Shadow of watchdog compare value and enable
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      cmp_r <= 16'h0000;
      wden_r <= 1'b0;
    end
    else if (wr_i && ce_i)
    begin
      if (addr_i == 8'h24) cmp_r[7:0] <= wdata_i;
      if (addr_i == 8'h34) cmp_r[15:8] <= wdata_i;
      if (addr_i == 8'h00) wden_r <= wdata_i[6];
    end
  end
  property p_rd_idle;
    @(posedge core_clk_i) disable iff (rst_i) !$past(rd_i) && $past(ce_i) |-> rdata_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_rd_unmapped;
    @(posedge core_clk_i) disable iff (rst_i) rd_i && ce_i && addr_i == 8'hFF |=> rdata_o == 8'h00;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  property p_rd_timer;
    @(posedge core_clk_i) disable iff (rst_i) rd_i && ce_i && addr_i == 8'h02 |=> rdata_o == $past(timer_o[7:0]);
  endproperty
  a_rd_timer: assert property (p_rd_timer) else $error("timer low read wrong");
  property p_wd_pulse;
    @(posedge core_clk_i) disable iff (rst_i) wd_reset_o |=> !wd_reset_o;
  endproperty
  a_wd_pulse: assert property (p_wd_pulse) else $error("watchdog pulse too long");
  property p_wd_cmp;
    @(posedge core_clk_i) disable iff (rst_i) wd_reset_o |-> wden_r && $past(timer_o) == cmp_r;
  endproperty
  a_wd_cmp: assert property (p_wd_cmp) else $error("watchdog pulse without match");
  property p_pin_rst;
    @(posedge core_clk_i) rst_i |=> module_pin_o == '1 && timer_o == 16'h0000 && !wd_reset_o;
  endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("reset values wrong");
  property p_freeze;
    @(posedge core_clk_i) disable iff (rst_i) !ce_i |=> $stable(timer_o) && $stable(module_pin_o);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
  property p_timer_inc;
    @(posedge core_clk_i) disable iff (rst_i) timer_o != $past(timer_o) && !$past(wr_i) && !$past(wd_reset_o)
      && !wd_reset_o |-> timer_o == $past(timer_o) + 16'h0001;
  endproperty
  a_timer_inc: assert property (p_timer_inc) else $error("timer step not one");
endmodule : counter_array_checker
bind counter_array_pwm_watchdog counter_array_checker #(.NUM_MODULES(NUM_MODULES)) checker_inst (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .module_pin_o(module_pin_o), .wd_reset_o(wd_reset_o), .timer_o(timer_o));

// *** tb/test_counter_array_pwm_watchdog.sv ***
// Self-checking bench for the counter array block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module test_counter_array_pwm_watchdog;
  logic core_clk_i, rst_i, ce_i, count_src_i, wr_i, rd_i, wd_reset_o;
  logic [7:0] addr_i, wdata_i, rdata_o;
  logic [4:0] module_pin_o, expin;
  logic [15:0] timer_o, t1, t2;
  logic [7:0] act [5], rld [5], a1 [5], a2 [5];
  logic [31:0] seed = 32'hA7289B28;
  int n_fail = 0, n_tests = 0, n_wd = 0;
  counter_array_pwm_watchdog counter_array_pwm_watchdog_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .ce_i(ce_i), .count_src_i(count_src_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .module_pin_o(module_pin_o), .wd_reset_o(wd_reset_o), .timer_o(timer_o));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1;
    `CHK("rdata", e, rdata_o)
  endtask : rd
  // Watchdog run from 1300h against compare 1310h, counting reset pulses
  // Also checks the module four pin toggle and the sticky match status
  task automatic wd_run(input logic [7:0] md, input logic [7:0] en, input bit rf, input int e, input bit tg,
    input logic [7:0] st);
    logic p0;
    wr(8'h01, 8'h00);
    wr(8'h05, 8'h1F);
    wr(8'h02, 8'h00);
    wr(8'h03, 8'h13);
    wr(8'h14, md);
    wr(8'h24, 8'h10);
    wr(8'h34, 8'h13);
    wr(8'h00, en);
    n_wd = 0;
    #1;
    p0 = module_pin_o[4];
    wr(8'h01, 8'h01);
    if (rf)
    begin
      wr(8'h24, 8'h00);
      wr(8'h34, timer_o[15:8]);
    end
    repeat (40) @(posedge core_clk_i);
    #1;
    `CHK("wd pulses", e, n_wd)
    `CHK("module four pin", p0 ^ tg, module_pin_o[4])
    rd(8'h05, st);
  endtask : wd_run
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  // Clock, hang guard and pulse counter
  initial
  begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  initial
  begin
    #1000000;
    n_fail++;
    conclude();
  end
  always @(posedge core_clk_i) if (wd_reset_o === 1'b1) n_wd++;
  // Main sequence
  initial
  begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    count_src_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'b0;
    #1;
    `CHK("reset pins", 5'h1F, module_pin_o)
    rd(8'h02, 8'h00);
    rd(8'h13, 8'h00);
    rd(8'hFF, 8'h00);
    for (logic [7:0] n = 0; n < 5; n++)
    begin
      seed = xs(seed);
      act[n] = (n == 0) ? 8'h00 : (n == 1) ? 8'hFF : seed[7:0];
      rld[n] = seed[15:8];
      wr(8'h20 + n, act[n]);
      wr(8'h30 + n, rld[n]);
      wr(8'h10 + n, (n == 3) ? 8'h02 : 8'h42);
    end
    rd(8'h11, 8'h42);
    a1 = act;
    t1 = 16'h0000;
    wr(8'h01, 8'h01);
    for (int k = 0; k < 600; k++)
    begin
      @(posedge core_clk_i);
      #1;
      if (t1[7:0] == 8'hFF && timer_o[7:0] == 8'h00) act = rld;
      for (int m = 0; m < 5; m++) expin[m] = (m == 3) ? 1'b1 : (t2[7:0] >= a2[m]);
      if (k > 3)
      begin
        `CHK("timer", t1 + 16'h0001, timer_o)
        `CHK("pwm pins", expin, module_pin_o)
      end
      t2 = t1;
      a2 = a1;
      t1 = timer_o;
      a1 = act;
    end
    wr(8'h01, 8'h00);
    wr(8'h00, 8'h01);
    wr(8'h02, 8'h00);
    wr(8'h03, 8'h00);
    wr(8'h01, 8'h01);
    repeat (10)
    begin
      @(posedge core_clk_i);
      count_src_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      count_src_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
    end
    repeat (6) @(posedge core_clk_i);
    #1;
    `CHK("source count", 16'h000A, timer_o)
    wr(8'h00, 8'h00);
    @(posedge core_clk_i);
    ce_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    ce_i <= 1'b1;
    wd_run(8'h4C, 8'h40, 1'b0, 1, 1'b1, 8'h10);
    wd_run(8'h48, 8'h40, 1'b0, 1, 1'b0, 8'h10);
    wd_run(8'h4C, 8'h00, 1'b0, 0, 1'b1, 8'h10);
    wd_run(8'h4C, 8'h40, 1'b1, 0, 1'b0, 8'h00);
    // Modulation: pin starts low at timer low 00h and rises past compare 10h
    wd_run(8'h4A, 8'h40, 1'b0, 0, 1'b1, 8'h00);
    rd(8'h24, 8'h10);
    conclude();
  end
endmodule : test_counter_array_pwm_watchdog
